// *** rtl/bdm_pkg.sv ***
// Purpose: shared constants for the block data memory access link
// Assumes: one clock, byte-wide command link between host and device
// Notes:   codes, keys and memory shape used by both ends
package bdm_pkg;

  // command codes on the link
  localparam logic [7:0] BDM_CODE_CTRL_LO   = 8'h00;
  localparam logic [7:0] BDM_CODE_CTRL_HI   = 8'h01;
  localparam logic [7:0] BDM_CODE_CLASS     = 8'h3E;
  localparam logic [7:0] BDM_CODE_BLOCK     = 8'h3F;
  localparam logic [7:0] BDM_CODE_BUF_FIRST = 8'h40;
  localparam logic [7:0] BDM_CODE_BUF_LAST  = 8'h5F;
  localparam logic [7:0] BDM_CODE_CSUM      = 8'h60;
  localparam logic [7:0] BDM_CODE_ACCESS    = 8'h61;
  localparam logic [7:0] BDM_ACCESS_ENABLE  = 8'h00;
  localparam logic [7:0] BDM_CSUM_FULL      = 8'hFF;
  localparam logic [7:0] BDM_ZERO_BYTE      = 8'h00;

  // control word values
  localparam logic [15:0] BDM_UNSEAL_KEY  = 16'h8000;
  localparam logic [15:0] BDM_SEAL_SUBCMD = 16'h0030;
  localparam int          BDM_SS_BIT      = 13;
  localparam logic [15:0] BDM_STATUS_ZERO = 16'h0000;

  // data memory shape: 4 classes x 4 blocks x 32 bytes
  localparam int BDM_BLOCK_BYTES = 32;
  localparam int BDM_OFS_BITS    = 5;
  localparam int BDM_SEL_BITS    = 2;
  localparam int BDM_MEM_BYTES   = 512;
  localparam int BDM_ADDR_BITS   = 9;
  localparam logic [5:0] BDM_WCOUNT_MAX  = 6'h20;
  localparam logic [5:0] BDM_WCOUNT_ZERO = 6'h00;
  localparam logic [7:0] BDM_ROM_SEED    = 8'h5A;

  // host apb register map
  localparam logic [11:0] BDM_ADDR_CMD  = 12'h000;
  localparam logic [11:0] BDM_ADDR_STAT = 12'h004;
  localparam int BDM_CMD_WR_BIT   = 24;
  localparam int BDM_CMD_OFS_BIT  = 25;
  localparam int BDM_CMD_WORD_BIT = 26;

  typedef enum logic [1:0] {
    BDM_H_IDLE,
    BDM_H_LO,
    BDM_H_HI
  } bdm_hstate_type;

  // complemented checksum of a byte sum
  function automatic logic [7:0] bdm_complement(input logic [7:0] x);
    return BDM_CSUM_FULL - x;
  endfunction

  // power-on default of one data memory byte
  function automatic logic [7:0] bdm_rom_default(input int idx);
    logic [BDM_ADDR_BITS-1:0] a;
    a = idx[BDM_ADDR_BITS-1:0];
    return a[7:0] ^ BDM_ROM_SEED;
  endfunction

endpackage

// *** rtl/bdm_link_if.sv ***
// Purpose: byte command link between host controller and device
// Assumes: both ends on sys_clk
// Notes:   req is a level held until ack, ack is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface bdm_link_if;
  logic       req;
  logic       wr;
  logic [7:0] code;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;

  modport dev (
    input  req,
    input  wr,
    input  code,
    input  wdata,
    output ack,
    output rdata
  );

  modport host (
    output req,
    output wr,
    output code,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface
`default_nettype wire

// *** rtl/bdm_device.sv ***
// Purpose: device end, command window onto block data memory
// Assumes: host holds req until ack and drops it after
// Notes:   data memory restores its defaults on every reset
//
// Contract
// RL1 - class selector at 0x3E, unsealed only
// RL2 - block index at 0x3F picks 32-byte block
// RL3 - sealed refuses class, block, checksum, access
// RL4 - buffer bytes at codes 0x40 to 0x5F
// RL5 - host writes 255 minus byte sum
// RL6 - commit only on correct complemented checksum
// RL7 - writing 0x00 to 0x61 enables access
// RL8 - host addresses 0x40 plus offset mod 32
// RL9 - single buffer bytes rewritable in place
// RL10 - writes beyond 32 bytes are ignored
// RL11 - no range checking on written values
// RL12 - reset restores memory from defaults
// RL13 - device comes up unsealed after reset
// RL14 - two keys back to back unseal
// RL15 - sealed bit set while sealed
// RL16 - each unseal key equals 0x8000
// RL17 - plain extended reads work when sealed
// RL18 - host seals through control codes 0x00/0x01
// RL19 - new class or block reloads buffer
`timescale 1ns/10ps
`default_nettype none
module bdm_device
  import bdm_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  bdm_link_if.dev   lnk,
  output logic      sealed,
  output logic      access_enabled,
  output logic      commit_pulse
);

  logic [7:0] mem_q [BDM_MEM_BYTES];
  logic [7:0] buf_q [BDM_BLOCK_BYTES];
  logic [7:0] class_q;
  logic [7:0] block_q;
  logic [7:0] access_q;
  logic       access_en_q;
  logic       sealed_q;
  logic       key_stage_q;
  logic [7:0] ctl_lo_q;
  logic       reload_q;
  logic [5:0] wcount_q;
  logic       overflow_q;
  logic       ack_q;
  logic [7:0] rdata_q;
  logic       commit_q;

  // sum of the 32 buffer bytes, low byte kept
  function automatic logic [7:0] buf_sum(
    input logic [7:0] b [BDM_BLOCK_BYTES]
  );
    logic [7:0] s;
    s = BDM_ZERO_BYTE;
    for (int i = 0; i < BDM_BLOCK_BYTES; i++) begin
      s = s + b[i];
    end
    return s;
  endfunction

  // memory byte address of a block offset
  function automatic logic [BDM_ADDR_BITS-1:0] mem_addr(
    input logic [7:0]              cls,
    input logic [7:0]              blk,
    input logic [BDM_OFS_BITS-1:0] ofs
  );
    return {cls[BDM_SEL_BITS-1:0], blk[BDM_SEL_BITS-1:0], ofs};
  endfunction

  // link decode
  wire       take     = lnk.req & ~ack_q;
  wire       wr_take  = take & lnk.wr;
  wire [7:0] code     = lnk.code;
  wire       is_buf   = (code >= BDM_CODE_BUF_FIRST) &&
                        (code <= BDM_CODE_BUF_LAST);
  wire [7:0] buf_rel  = code - BDM_CODE_BUF_FIRST;
  wire [BDM_OFS_BITS-1:0] buf_ofs = buf_rel[BDM_OFS_BITS-1:0];

  // RL3 sealed write gating
  wire       wr_class  = wr_take & (code == BDM_CODE_CLASS) & ~sealed_q;
  wire       wr_block  = wr_take & (code == BDM_CODE_BLOCK) & ~sealed_q;
  wire       wr_csum   = wr_take & (code == BDM_CODE_CSUM) & ~sealed_q;
  wire       wr_access = wr_take & (code == BDM_CODE_ACCESS) & ~sealed_q;
  wire       wr_buf    = wr_take & is_buf & ~sealed_q;
  wire       wr_ctl_lo = wr_take & (code == BDM_CODE_CTRL_LO);
  wire       wr_ctl_hi = wr_take & (code == BDM_CODE_CTRL_HI);

  // RL10 byte writes past a full block
  wire       buf_over  = wr_buf & (wcount_q == BDM_WCOUNT_MAX);
  // RL9 single byte rewrite
  wire       buf_write = wr_buf & ~buf_over;

  // RL5 expected checksum of the buffer
  wire [7:0] csum_exp  = bdm_complement(buf_sum(buf_q));
  // RL6 commit gate
  wire       commit    = wr_csum & access_en_q & ~overflow_q &
                         ~reload_q & (lnk.wdata == csum_exp);

  // RL19 reload on reselect or enable
  wire       reload_set = (access_en_q & (wr_class | wr_block)) |
                          (wr_access & (lnk.wdata == BDM_ACCESS_ENABLE));

  // control word from two byte writes
  wire [15:0] ctl_word  = {lnk.wdata, ctl_lo_q};
  // RL16 key compare
  wire       key_hit    = wr_ctl_hi & (ctl_word == BDM_UNSEAL_KEY);
  wire       seal_cmd   = wr_ctl_hi & (ctl_word == BDM_SEAL_SUBCMD);

  // RL15 sealed bit in status word
  wire [15:0] status_word = BDM_STATUS_ZERO |
                            (16'(sealed_q) << BDM_SS_BIT);

  // RL17 read select, reserved codes read zero
  wire [7:0] rd_val =
    (code == BDM_CODE_CTRL_LO) ? status_word[7:0] :
    (code == BDM_CODE_CTRL_HI) ? status_word[15:8] :
    (code == BDM_CODE_CLASS)   ? (sealed_q ? BDM_ZERO_BYTE : class_q) :
    (code == BDM_CODE_BLOCK)   ? block_q :
    is_buf                     ? buf_q[buf_ofs] :
    (code == BDM_CODE_CSUM)    ? csum_exp :
    (code == BDM_CODE_ACCESS)  ? (sealed_q ? BDM_ZERO_BYTE : access_q) :
    BDM_ZERO_BYTE;

  // link answer, one cycle after req is seen
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q   <= 1'b0;
      rdata_q <= BDM_ZERO_BYTE;
    end else begin
      ack_q <= take;
      if (take && !lnk.wr) begin
        rdata_q <= rd_val;
      end
    end
  end

  // RL1 class select
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      class_q <= BDM_ZERO_BYTE;
    end else if (wr_class) begin
      class_q <= lnk.wdata;
    end
  end

  // RL2 block index select
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      block_q <= BDM_ZERO_BYTE;
    end else if (wr_block) begin
      block_q <= lnk.wdata;
    end
  end

  // RL7 access enable on 0x00
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      access_q    <= BDM_CSUM_FULL;
      access_en_q <= 1'b0;
    end else if (wr_access) begin
      access_q    <= lnk.wdata;
      access_en_q <= (lnk.wdata == BDM_ACCESS_ENABLE);
    end
  end

  // reload one cycle later so the new selection is in place
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reload_q <= 1'b0;
    end else begin
      reload_q <= reload_set;
    end
  end

  // RL10 count of byte writes since the last load or commit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wcount_q   <= BDM_WCOUNT_ZERO;
      overflow_q <= 1'b0;
    end else if (reload_q || commit) begin
      wcount_q   <= BDM_WCOUNT_ZERO;
      overflow_q <= 1'b0;
    end else if (buf_over) begin
      overflow_q <= 1'b1;
    end else if (buf_write) begin
      wcount_q <= wcount_q + 6'h01;
    end
  end

  // RL4 block buffer, reload wins over a byte write
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < BDM_BLOCK_BYTES; i++) begin
        buf_q[i] <= BDM_ZERO_BYTE;
      end
    end else if (reload_q) begin
      for (int i = 0; i < BDM_BLOCK_BYTES; i++) begin
        buf_q[i] <= mem_q[mem_addr(class_q, block_q, BDM_OFS_BITS'(i))];
      end
    end else if (buf_write) begin
      // RL11 any value accepted
      buf_q[buf_ofs] <= lnk.wdata;
    end
  end

  // RL12 memory defaults restored at reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < BDM_MEM_BYTES; i++) begin
        mem_q[i] <= bdm_rom_default(i);
      end
    end else if (commit) begin
      // RL6 whole block written at once
      for (int i = 0; i < BDM_BLOCK_BYTES; i++) begin
        mem_q[mem_addr(class_q, block_q, BDM_OFS_BITS'(i))] <= buf_q[i];
      end
    end
  end

  // low control byte held until the high byte arrives
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_lo_q <= BDM_ZERO_BYTE;
    end else if (wr_ctl_lo) begin
      ctl_lo_q <= lnk.wdata;
    end
  end

  // RL13 unsealed after reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sealed_q    <= 1'b0;
      key_stage_q <= 1'b0;
    end else if (wr_ctl_hi) begin
      if (seal_cmd) begin
        sealed_q    <= 1'b1;
        key_stage_q <= 1'b0;
      // RL14 second key must follow the first directly
      end else if (sealed_q && key_hit && key_stage_q) begin
        sealed_q    <= 1'b0;
        key_stage_q <= 1'b0;
      end else begin
        // RL14 any other word breaks the pair
        key_stage_q <= sealed_q & key_hit;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      commit_q <= 1'b0;
    end else begin
      commit_q <= commit;
    end
  end

  assign lnk.ack        = ack_q;
  assign lnk.rdata      = rdata_q;
  assign sealed         = sealed_q;
  assign access_enabled = access_en_q;
  assign commit_pulse   = commit_q;

endmodule
`default_nettype wire

// *** rtl/bdm_host.sv ***
// Purpose: host end, apb-driven issuer of link commands
// Assumes: software orders each command through the cmd register
// Notes:   keeps a running byte sum so software gets the checksum
`timescale 1ns/10ps
`default_nettype none
module bdm_host
  import bdm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  bdm_link_if.host         lnk
);

  bdm_hstate_type state_q;
  logic [15:0]    data_q;
  logic [7:0]     code_q;
  logic           wr_q;
  logic           req_q;
  logic [7:0]     rdata_q;
  logic [7:0]     sum_q;
  logic           c_word_q;

  // RL8 offset to buffer code, mod 32
  function automatic logic [7:0] param_code(input logic [7:0] ofs);
    return BDM_CODE_BUF_FIRST + {3'h0, ofs[BDM_OFS_BITS-1:0]};
  endfunction

  wire        apb_acc   = psel & penable;
  wire        hit_cmd   = (paddr == BDM_ADDR_CMD);
  wire        hit_stat  = (paddr == BDM_ADDR_STAT);
  wire        busy      = (state_q != BDM_H_IDLE);
  wire        start     = apb_acc & pwrite & hit_cmd & ~busy;
  wire        c_word    = pwdata[BDM_CMD_WORD_BIT];
  wire [7:0]  c_code    = pwdata[BDM_CMD_OFS_BIT] ?
                          param_code(pwdata[23:16]) : pwdata[23:16];
  wire        done      = req_q & lnk.ack;
  wire        is_buf_wr = wr_q & (code_q >= BDM_CODE_BUF_FIRST) &&
                          (code_q <= BDM_CODE_BUF_LAST);
  wire        resel     = wr_q & ((code_q == BDM_CODE_CLASS) ||
                                  (code_q == BDM_CODE_BLOCK));
  // RL5 255 minus byte sum
  wire [7:0]  csum      = bdm_complement(sum_q);
  wire [31:0] stat_word = {8'h00, csum, rdata_q, 7'h00, busy};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= BDM_H_IDLE;
      req_q   <= 1'b0;
    end else begin
      unique case (state_q)
        BDM_H_IDLE: begin
          if (start) begin
            state_q <= BDM_H_LO;
            req_q   <= 1'b1;
          end
        end
        BDM_H_LO: begin
          if (done) begin
            req_q   <= 1'b0;
            // RL18 only a control word takes two transfers
            state_q <= c_word_q ? BDM_H_HI : BDM_H_IDLE;
          end
        end
        BDM_H_HI: begin
          // second half of a control word, nothing issued in between
          req_q <= ~req_q | ~done;
          if (done) begin
            state_q <= BDM_H_IDLE;
            req_q   <= 1'b0;
          end
        end
      endcase
    end
  end

  // latched command; control words go out as code 0x00 then 0x01
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      data_q <= BDM_STATUS_ZERO;
      code_q <= BDM_ZERO_BYTE;
      wr_q   <= 1'b0;
    end else if (start) begin
      data_q <= pwdata[15:0];
      code_q <= c_word ? BDM_CODE_CTRL_LO : c_code;
      wr_q   <= pwdata[BDM_CMD_WR_BIT] | c_word;
    end else if (done && state_q == BDM_H_LO &&
                 code_q == BDM_CODE_CTRL_LO && c_word_q) begin
      code_q <= BDM_CODE_CTRL_HI;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      c_word_q <= 1'b0;
    end else if (start) begin
      c_word_q <= c_word;
    end
  end

  // read data and running sum of buffer bytes written
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= BDM_ZERO_BYTE;
      sum_q   <= BDM_ZERO_BYTE;
    end else if (done) begin
      if (!wr_q) begin
        rdata_q <= lnk.rdata;
      end
      if (resel) begin
        sum_q <= BDM_ZERO_BYTE;
      end else if (is_buf_wr) begin
        sum_q <= sum_q + data_q[7:0];
      end
    end
  end

  assign lnk.req   = req_q;
  assign lnk.wr    = wr_q;
  assign lnk.code  = code_q;
  assign lnk.wdata = (code_q == BDM_CODE_CTRL_HI && c_word_q) ?
                     data_q[15:8] : data_q[7:0];
  assign pready    = 1'b1;
  assign pslverr   = apb_acc & ~(hit_cmd | hit_stat);
  assign prdata    = (apb_acc & ~pwrite & hit_stat) ? stat_word :
                     32'h0000_0000;

endmodule
`default_nettype wire

// *** tb/bdm_link_asserts.sv ***
// Purpose: link handshake and device status checks
// Assumes: single sys_clk domain, rstn async active low
// Notes:   watches the link between host and device ends
`timescale 1ns/10ps
`default_nettype none
module bdm_link_asserts
  import bdm_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       req,
  input wire logic       wr,
  input wire logic [7:0] code,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       sealed,
  input wire logic       access_enabled,
  input wire logic       commit_pulse
);
  wire take      = req & ~ack;
  wire csum_take = take & wr & (code == BDM_CODE_CSUM);
  wire hi_take   = take & wr & (code == BDM_CODE_CTRL_HI);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_ack_next; take |=> ack; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack missing after request");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_req_drop; ack |=> !req; endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("request held after ack");
  property p_req_hold;
    take |=> req && $stable(code) && $stable(wdata) && $stable(wr);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before ack");
  property p_reset_open; $rose(rstn) |-> !sealed; endproperty
  a_reset_open: assert property (p_reset_open)
    else $error("sealed right after reset");
  property p_sealed_cls;
    sealed && take && !wr && code == BDM_CODE_CLASS
      |=> rdata == BDM_ZERO_BYTE;
  endproperty
  a_sealed_cls: assert property (p_sealed_cls)
    else $error("class readable while sealed");
  property p_access_on;
    take && wr && !sealed && code == BDM_CODE_ACCESS
      && wdata == BDM_ACCESS_ENABLE |=> ##[0:1] access_enabled;
  endproperty
  a_access_on: assert property (p_access_on)
    else $error("access not enabled");
  // commit only follows a checksum write
  property p_commit_cause;
    commit_pulse |-> !sealed && ($past(csum_take, 1)
      || $past(csum_take, 2) || $past(csum_take, 3));
  endproperty
  a_commit_cause: assert property (p_commit_cause)
    else $error("commit without checksum write");
  property p_seal_cause;
    $changed(sealed) |-> $past(hi_take, 1) || $past(hi_take, 2);
  endproperty
  a_seal_cause: assert property (p_seal_cause)
    else $error("sealed changed without control word");

  c_commit: cover property (commit_pulse);
  c_seal:   cover property ($rose(sealed));
  c_unseal: cover property ($fell(sealed));
  c_access: cover property ($rose(access_enabled));
endmodule
`default_nettype wire

// *** tb/block_data_memory_access_tb.sv ***
// Purpose: host and device ends joined, driven through apb
// Assumes: 50 MHz sys_clk, zero-wait apb, busy polled between commands
// Notes:   expectations come from the default pattern and bench sums
`timescale 1ns/10ps
`default_nettype none
module block_data_memory_access_tb;
  import bdm_pkg::*;
  logic        sys_clk    = 1'b0;
  logic        rstn       = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sealed;
  logic        access_enabled;
  logic        commit_pulse;
  logic [31:0] rv;
  logic        rerr;
  int          mismatches = 0;
  int          n_checks   = 0;
  int          commits    = 0;
  integer      seed       = 32'h747e_9d3d;
  logic [7:0]  dat [32];
  logic [7:0]  sum;
  logic [7:0]  cls;
  logic [1:0]  blk;
  logic [4:0]  ofs;

  always #10 sys_clk = ~sys_clk;

  bdm_link_if lnk_if ();
  bdm_host bdm_host_inst (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk_if));
  bdm_device bdm_device_inst (.sys_clk(sys_clk), .rstn(rstn),
    .lnk(lnk_if), .sealed(sealed), .access_enabled(access_enabled),
    .commit_pulse(commit_pulse));
  bdm_link_asserts bdm_link_asserts_inst (.sys_clk(sys_clk), .rstn(rstn),
    .req(lnk_if.req), .wr(lnk_if.wr), .code(lnk_if.code),
    .wdata(lnk_if.wdata), .ack(lnk_if.ack), .rdata(lnk_if.rdata),
    .sealed(sealed), .access_enabled(access_enabled),
    .commit_pulse(commit_pulse));

  always @(posedge sys_clk) begin
    if (commit_pulse === 1'b1)
      commits <= commits + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rv   = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // m = {control word, offset mode, write}
  task automatic cmd(input logic [2:0] m, input logic [7:0] c,
                     input logic [15:0] d);
    int i;
    apb(1'b1, BDM_ADDR_CMD, {5'h00, m, c, d});
    i  = 0;
    rv = 32'h0000_0001;
    while (rv[0] !== 1'b0 && i < 50) begin
      apb(1'b0, BDM_ADDR_STAT, 32'h0000_0000);
      i++;
    end
    if (i >= 50)
      mismatches++;
  endtask

  // the 33rd write flips its data so a wrongly kept byte breaks the checksum
  task automatic fill(input int n);
    for (int i = 0; i < n; i++)
      cmd(3'b001, {3'b010, i[4:0]},
          {8'h00, dat[i % 32] ^ ((i > 31) ? 8'hFF : 8'h00)});
  endtask

  function automatic logic [7:0] rom_exp(input logic [1:0] c,
                                         input logic [1:0] b,
                                         input logic [4:0] o);
    logic [8:0] a;
    a = {c, b, o};
    return a[7:0] ^ 8'h5A;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #400_000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    check({31'h0000_0000, sealed}, 32'h0000_0000);
    cmd(3'b001, BDM_CODE_ACCESS, 16'h0000);
    check({31'h0000_0000, access_enabled}, 32'h0000_0001);
    for (int k = 0; k < 5; k++) begin
      cls = 8'($random(seed));
      blk = 2'($random(seed));
      ofs = (k == 0) ? 5'h1F : 5'($random(seed));
      cmd(3'b001, BDM_CODE_CLASS, {8'h00, cls});
      cmd(3'b001, BDM_CODE_BLOCK, {14'h0000, blk});
      cmd(3'b000, {3'b010, ofs}, 16'h0000);
      check(rv[15:8], rom_exp(cls[1:0], blk, ofs));
      cmd(3'b000, BDM_CODE_CLASS, 16'h0000);
      check(rv[15:8], cls);
    end
    sum = 8'h00;
    for (int i = 0; i < 32; i++) begin
      dat[i] = 8'($random(seed));
      sum    = sum + dat[i];
    end
    fill(32);
    apb(1'b0, BDM_ADDR_STAT, 32'h0000_0000);
    check(rv[23:16], 8'hFF - sum);
    cmd(3'b001, BDM_CODE_CSUM, {8'h00, 8'hFE - sum});
    check(commits, 0);
    cmd(3'b001, BDM_CODE_CSUM, {8'h00, 8'hFF - sum});
    check(commits, 1);
    cmd(3'b001, BDM_CODE_BLOCK, {14'h0000, blk});
    cmd(3'b000, 8'h45, 16'h0000);
    check(rv[15:8], dat[5]);
    cmd(3'b011, 8'd37, 16'h00A5);
    cmd(3'b000, 8'h45, 16'h0000);
    check(rv[15:8], 8'hA5);
    cmd(3'b000, 8'h46, 16'h0000);
    check(rv[15:8], dat[6]);
    cmd(3'b001, BDM_CODE_BLOCK, {14'h0000, blk});
    fill(33);
    cmd(3'b001, BDM_CODE_CSUM, {8'h00, 8'hFF - sum});
    check(commits, 1);
    cmd(3'b101, 8'h00, BDM_SEAL_SUBCMD);
    check({31'h0000_0000, sealed}, 32'h0000_0001);
    cmd(3'b000, BDM_CODE_CTRL_HI, 16'h0000);
    check(rv[15:8], 8'(1 << (BDM_SS_BIT - 8)));
    cmd(3'b000, BDM_CODE_CTRL_LO, 16'h0000);
    check(rv[15:8], 8'h00);
    cmd(3'b001, BDM_CODE_CLASS, {8'h00, ~cls});
    cmd(3'b000, BDM_CODE_CLASS, 16'h0000);
    check(rv[15:8], 8'h00);
    cmd(3'b000, BDM_CODE_BLOCK, 16'h0000);
    check(rv[15:8], {6'h00, blk});
    cmd(3'b101, 8'h00, BDM_UNSEAL_KEY);
    cmd(3'b101, 8'h00, 16'h1234);
    cmd(3'b101, 8'h00, BDM_UNSEAL_KEY);
    check({31'h0000_0000, sealed}, 32'h0000_0001);
    cmd(3'b101, 8'h00, BDM_UNSEAL_KEY);
    check({31'h0000_0000, sealed}, 32'h0000_0000);
    cmd(3'b000, BDM_CODE_CTRL_HI, 16'h0000);
    check(rv[15:8], 8'h00);
    cmd(3'b000, BDM_CODE_CLASS, 16'h0000);
    check(rv[15:8], cls);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check({31'h0000_0000, rerr}, 32'h0000_0001);
    cmd(3'b101, 8'h00, BDM_SEAL_SUBCMD);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    check({31'h0000_0000, sealed}, 32'h0000_0000);
    cmd(3'b001, BDM_CODE_ACCESS, 16'h0000);
    cmd(3'b001, BDM_CODE_CLASS, {8'h00, cls});
    cmd(3'b001, BDM_CODE_BLOCK, {14'h0000, blk});
    cmd(3'b000, 8'h45, 16'h0000);
    check(rv[15:8], rom_exp(cls[1:0], blk, 5'h05));
    report_and_stop();
  end
endmodule
`default_nettype wire
